// ---- logic/adcsq_consts.vh ----
// Constants for the converter scan sequencer: register offsets,
// field positions, reset values and timing counts.
// Assumes a 32-bit classic Wishbone slave with byte addressing.
//
// Operation
// - Scan converts four adjacent inputs after delay
// - Single scan: four results, clear start, EOC
// - Interrupt rises together with end-of-conversion flag
// - Continuous scan repeats groups, EOC per group
// - Start cleared: scan finishes its group, single channel its conversion, then stop
// - Status byte with flags, pointer; resets 30h
// - Overrun cleared by writing one or by disable
// - EOC set at group or sequence end, cleared by result read
// - Busy reads one from start until the sequence stops, sampling delays included
// - Pointer loads 11 at start, increments per result
// - Control one: enable bit0, irq enable bit2
// - Disable aborts and clears flags and start
// - Interrupt at sequence end or buffer full
// - Scan field: 00 single, 01 four-channel
// - Repeat bit: stop after cycle or repeat
// - Mode writes ignored while start set
// - Single conversion lands in first result register
// - Single channel continuous fills four, then wraps
// - Each conversion takes ten converter clocks
`ifndef ADCSQ_CONSTS_VH
`define ADCSQ_CONSTS_VH

// Byte offsets, one register per aligned word
`define ADCSQ_OFS_STATUS   8'h00
`define ADCSQ_OFS_CTRL_ONE 8'h04
`define ADCSQ_OFS_CTRL_TWO 8'h08
`define ADCSQ_OFS_CTRL_THR 8'h0C
`define ADCSQ_OFS_RES_BASE 8'h10
`define ADCSQ_OFS_RES_LAST 8'h1C

// Status fields
`define ADCSQ_ST_EOC     0
`define ADCSQ_ST_BUSY    1
`define ADCSQ_ST_OVF     2
`define ADCSQ_ST_PTR_LO  4
`define ADCSQ_ST_RESET   8'h30
`define ADCSQ_PTR_RESET  2'h3

// Control one fields
`define ADCSQ_C1_EN      0
`define ADCSQ_C1_IRQ     2

// Control two fields
`define ADCSQ_C2_START   7
`define ADCSQ_C2_SCAN_HI 6
`define ADCSQ_C2_SCAN_LO 5
`define ADCSQ_C2_REPEAT  4
`define ADCSQ_C2_CHAN_HI 3

// Control three fields: divider 2:0, delay 5:3
`define ADCSQ_C3_DIV_HI  2
`define ADCSQ_C3_DLY_LO  3
`define ADCSQ_C3_DLY_HI  5

// Converter clocks per conversion
`define ADCSQ_CONV_TICKS 7'h0A
`define ADCSQ_LAST_IDX   2'h3

`endif

// ---- logic/adcsq_clkdiv.v ----
// Converter clock divider: one-cycle enable pulse every 2^n cycles.
// Assumes the divider code is only changed while disabled.
`timescale 1ns/1ns
`default_nettype none

module adcsq_clkdiv (
	input  wire       i_clock,
	input  wire       i_rst_b,
	input  wire       i_run,
	input  wire [2:0] i_div_code,
	output reg        o_tick
);

	reg  [4:0] count_q;
	reg  [4:0] limit;

	// Codes above 5 are reserved; they act as divide by 32
	always @* begin
		if (i_div_code > 3'h5)
			limit = 5'h1F;
		else
			limit = (5'h01 << i_div_code) - 5'h01;
	end

	always @(posedge i_clock) begin
		if (!i_rst_b || !i_run) begin
			count_q <= 5'h00;
			o_tick  <= 1'b0;
		end else if (count_q >= limit) begin
			count_q <= 5'h00;
			o_tick  <= 1'b1;
		end else begin
			count_q <= count_q + 5'h01;
			o_tick  <= 1'b0;
		end
	end

endmodule // adcsq_clkdiv

`default_nettype wire

// ---- logic/adcsq_convtimer.v ----
// One conversion: sampling delay, then ten converter clocks.
// Assumes i_tick is a one-cycle enable at the converter rate.
`timescale 1ns/1ns
`default_nettype none

`include "adcsq_consts.vh"

module adcsq_convtimer (
	input  wire       i_clock,
	input  wire       i_rst_b,
	input  wire       i_abort,
	input  wire       i_launch,
	input  wire       i_tick,
	input  wire [2:0] i_delay_code,
	output reg        o_sampling,
	output reg        o_converting,
	output reg        o_done
);

	reg  [6:0] count_q;

	// Reserved code 7 behaves as the longest delay
	function [6:0] delay_ticks;
		input [2:0] code;
		begin
			if (code == 3'h7)
				delay_ticks = 7'h40;
			else
				delay_ticks = 7'h01 << code;
		end
	endfunction

	always @(posedge i_clock) begin
		if (!i_rst_b || i_abort) begin
			count_q      <= 7'h00;
			o_sampling   <= 1'b0;
			o_converting <= 1'b0;
			o_done       <= 1'b0;
		end else begin
			o_done <= 1'b0;
			if (i_launch) begin
				o_sampling <= 1'b1;
				count_q    <= delay_ticks(i_delay_code) - 7'h01;
			end else if (i_tick && o_sampling) begin
				if (count_q == 7'h00) begin
					o_sampling   <= 1'b0;
					o_converting <= 1'b1;
					count_q      <= `ADCSQ_CONV_TICKS - 7'h01;
				end else begin
					count_q <= count_q - 7'h01;
				end
			end else if (i_tick && o_converting) begin
				if (count_q == 7'h00) begin
					o_converting <= 1'b0;
					o_done       <= 1'b1;
				end else begin
					count_q <= count_q - 7'h01;
				end
			end
		end
	end

endmodule // adcsq_convtimer

`default_nettype wire

// ---- logic/adcsq_top.v ----
// Scan sequencer for an 8-bit, 12-input converter: registers,
// sequencing, result buffer and flags.
// Assumes a classic Wishbone master and an analog core whose result
// is valid when the tenth converter clock of a conversion ends.
`timescale 1ns/1ns
`default_nettype none

`include "adcsq_consts.vh"

module adcsq_top (
	input  wire        i_clock,
	input  wire        i_rst_b,
	input  wire        i_wb_cyc,
	input  wire        i_wb_stb,
	input  wire        i_wb_we,
	input  wire [7:0]  i_wb_adr,
	input  wire [3:0]  i_wb_sel,
	input  wire [31:0] i_wb_dat,
	output reg  [31:0] o_wb_dat,
	output reg         o_wb_ack,
	input  wire [7:0]  i_sar_result,
	output reg  [3:0]  o_mux_chan,
	output wire        o_sample_hold,
	output wire        o_convert,
	output reg         o_core_power,
	output reg         o_irq
);

	////////////////////////////////////////////////////////////////
	// Declarations
	////////////////////////////////////////////////////////////////

	localparam ST_IDLE = 2'b01;
	localparam ST_RUN  = 2'b10;

	reg  [1:0]  st_q;
	reg  [1:0]  st_d;
	reg         en_q;
	reg         irq_en_q;
	reg         start_q;
	reg         start_d;
	reg  [1:0]  scan_q;
	reg         repeat_q;
	reg  [3:0]  chan_q;
	reg  [5:0]  ctrl3_q;
	reg         eoc_q;
	reg         eoc_d;
	reg         ovf_q;
	reg         ovf_d;
	reg  [1:0]  ptr_q;
	reg  [1:0]  ptr_d;
	reg  [1:0]  idx_q;
	reg  [1:0]  idx_d;
	reg  [3:0]  base_q;
	reg  [3:0]  chan_d;
	reg         launch_q;
	reg         launch_d;
	reg  [7:0]  result_q [0:3];
	reg  [31:0] rdata;
	reg         stop;
	reg         group_end;

	wire        req;
	wire        wr;
	wire        rd;
	wire        wr_lane;
	wire        wr_ctrl1;
	wire        wr_ctrl2;
	wire        wr_ctrl3;
	wire        wr_status;
	wire        rd_result;
	wire [1:0]  rd_slot;
	wire        tick;
	wire        done;
	wire        busy;
	wire        abort;
	wire        single;
	wire [1:0]  wr_slot;
	wire [3:0]  unread;
	wire [3:0]  hit_unread;

	// Any of the four result words
	function is_result;
		input [7:0] adr;
		begin
			is_result = (adr >= `ADCSQ_OFS_RES_BASE) &&
				(adr <= `ADCSQ_OFS_RES_LAST) &&
				(adr[1:0] == 2'h0);
		end
	endfunction

	////////////////////////////////////////////////////////////////
	// Bus decode
	////////////////////////////////////////////////////////////////

	assign req       = i_wb_cyc && i_wb_stb && !o_wb_ack;
	assign wr        = req && i_wb_we;
	assign rd        = req && !i_wb_we;
	assign wr_lane   = wr && i_wb_sel[0];
	assign wr_ctrl1  = wr_lane && (i_wb_adr == `ADCSQ_OFS_CTRL_ONE);
	assign wr_ctrl2  = wr_lane && (i_wb_adr == `ADCSQ_OFS_CTRL_TWO);
	assign wr_ctrl3  = wr_lane && (i_wb_adr == `ADCSQ_OFS_CTRL_THR);
	assign wr_status = wr_lane && (i_wb_adr == `ADCSQ_OFS_STATUS);
	assign rd_result = rd && is_result(i_wb_adr);
	assign rd_slot   = i_wb_adr[3:2];

	assign busy   = (st_q == ST_RUN);
	assign abort  = !en_q;
	assign single = !scan_q[0];

	always @* begin
		rdata = 32'h0000_0000;
		if (i_wb_adr == `ADCSQ_OFS_STATUS) begin
			rdata[`ADCSQ_ST_EOC]  = eoc_q;
			rdata[`ADCSQ_ST_BUSY] = busy;
			rdata[`ADCSQ_ST_OVF]  = ovf_q;
			rdata[5:4]            = ptr_q;
		end else if (i_wb_adr == `ADCSQ_OFS_CTRL_ONE) begin
			rdata[`ADCSQ_C1_EN]  = en_q;
			rdata[`ADCSQ_C1_IRQ] = irq_en_q;
		end else if (i_wb_adr == `ADCSQ_OFS_CTRL_TWO) begin
			rdata[7:0] = {start_q, scan_q, repeat_q, chan_q};
		end else if (i_wb_adr == `ADCSQ_OFS_CTRL_THR) begin
			rdata[5:0] = ctrl3_q;
		end else if (is_result(i_wb_adr)) begin
			rdata[7:0] = result_q[rd_slot];
		end
	end

	always @(posedge i_clock) begin
		if (!i_rst_b) begin
			o_wb_ack <= 1'b0;
			o_wb_dat <= 32'h0000_0000;
		end else begin
			// Unmapped words answer with zero, never stall
			o_wb_ack <= req;
			o_wb_dat <= rd ? rdata : 32'h0000_0000;
		end
	end

	////////////////////////////////////////////////////////////////
	// Control registers
	////////////////////////////////////////////////////////////////

	always @(posedge i_clock) begin
		if (!i_rst_b) begin
			en_q     <= 1'b0;
			irq_en_q <= 1'b0;
			scan_q   <= 2'h0;
			repeat_q <= 1'b0;
			chan_q   <= 4'h0;
			ctrl3_q  <= 6'h00;
		end else begin
			if (wr_ctrl1) begin
				en_q     <= i_wb_dat[`ADCSQ_C1_EN];
				irq_en_q <= i_wb_dat[`ADCSQ_C1_IRQ];
			end
			if (wr_ctrl2) begin
				chan_q <= i_wb_dat[`ADCSQ_C2_CHAN_HI:0];
				if (!start_q) begin
					scan_q   <= i_wb_dat[6:5];
					repeat_q <= i_wb_dat[`ADCSQ_C2_REPEAT];
				end
			end
			if (wr_ctrl3)
				ctrl3_q <= i_wb_dat[5:0];
		end
	end

	////////////////////////////////////////////////////////////////
	// Sequencer
	////////////////////////////////////////////////////////////////

	assign wr_slot = ptr_q + 2'h1;

	always @* begin
		st_d     = st_q;
		start_d  = start_q;
		idx_d    = idx_q;
		ptr_d    = ptr_q;
		chan_d   = o_mux_chan;
		launch_d = 1'b0;
		eoc_d    = eoc_q;
		ovf_d    = ovf_q;
		stop     = 1'b0;
		group_end = 1'b0;

		// Software side of the flags; a hardware set below wins
		if (rd_result)
			eoc_d = 1'b0;
		if (wr_status && i_wb_dat[`ADCSQ_ST_OVF])
			ovf_d = 1'b0;
		if (wr_ctrl2 && !i_wb_dat[`ADCSQ_C2_START])
			start_d = 1'b0;

		case (st_q)
			ST_IDLE: begin
				if (wr_ctrl2 && i_wb_dat[`ADCSQ_C2_START] &&
						!start_q && en_q) begin
					start_d  = 1'b1;
					st_d     = ST_RUN;
					ptr_d    = `ADCSQ_PTR_RESET;
					idx_d    = 2'h0;
					chan_d   = i_wb_dat[`ADCSQ_C2_CHAN_HI:0];
					launch_d = 1'b1;
				end
			end
			ST_RUN: begin
				if (done) begin
					ptr_d     = wr_slot;
					group_end = (idx_q == `ADCSQ_LAST_IDX);
					if (single)
						stop = !repeat_q || !start_d;
					else
						stop = group_end &&
							!(repeat_q && start_d);
					if (hit_unread[wr_slot])
						ovf_d = 1'b1;
					if (stop || group_end)
						eoc_d = 1'b1;
					if (stop) begin
						st_d = ST_IDLE;
						if (!repeat_q)
							start_d = 1'b0;
					end else begin
						idx_d    = idx_q + 2'h1;
						launch_d = 1'b1;
						if (single)
							chan_d = base_q;
						else
							chan_d = base_q + {2'h0, idx_d};
					end
				end
			end
			default: begin
				st_d = ST_IDLE;
			end
		endcase
	end

	always @(posedge i_clock) begin
		if (!i_rst_b) begin
			st_q       <= ST_IDLE;
			start_q    <= 1'b0;
			idx_q      <= 2'h0;
			ptr_q      <= `ADCSQ_PTR_RESET;
			base_q     <= 4'h0;
			o_mux_chan <= 4'h0;
			launch_q   <= 1'b0;
			eoc_q      <= 1'b0;
			ovf_q      <= 1'b0;
		end else if (abort) begin
			// Disable kills the sequence and every flag
			st_q     <= ST_IDLE;
			start_q  <= 1'b0;
			idx_q    <= 2'h0;
			launch_q <= 1'b0;
			eoc_q    <= 1'b0;
			ovf_q    <= 1'b0;
		end else begin
			st_q       <= st_d;
			start_q    <= start_d;
			idx_q      <= idx_d;
			ptr_q      <= ptr_d;
			o_mux_chan <= chan_d;
			launch_q   <= launch_d;
			eoc_q      <= eoc_d;
			ovf_q      <= ovf_d;
			if (st_q == ST_IDLE && st_d == ST_RUN)
				base_q <= chan_d;
		end
	end

	////////////////////////////////////////////////////////////////
	// Result buffer and unread tracking
	////////////////////////////////////////////////////////////////

	always @(posedge i_clock) begin
		if (done && busy && !abort)
			result_q[wr_slot] <= i_sar_result;
	end

	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : g_slot
			reg unread_q;
			wire fill = done && busy && !abort &&
				(wr_slot == g);
			wire drain = rd_result && (rd_slot == g);
			always @(posedge i_clock) begin
				if (!i_rst_b || abort)
					unread_q <= 1'b0;
				else if (fill)
					unread_q <= 1'b1;
				else if (drain)
					unread_q <= 1'b0;
			end
			assign unread[g]     = unread_q;
			// Same-cycle read still counts as read
			assign hit_unread[g] = unread[g] && !drain;
		end
	endgenerate

	////////////////////////////////////////////////////////////////
	// Interrupt and analog core control
	////////////////////////////////////////////////////////////////

	always @(posedge i_clock) begin
		if (!i_rst_b) begin
			o_irq        <= 1'b0;
			o_core_power <= 1'b0;
		end else begin
			// Follows the flag, so a result read drops it too
			o_irq        <= eoc_d && irq_en_q && en_q;
			o_core_power <= en_q;
		end
	end

	adcsq_clkdiv u_clkdiv (
		.i_clock    (i_clock),
		.i_rst_b    (i_rst_b),
		.i_run      (busy),
		.i_div_code (ctrl3_q[`ADCSQ_C3_DIV_HI:0]),
		.o_tick     (tick)
	);

	adcsq_convtimer u_timer (
		.i_clock      (i_clock),
		.i_rst_b      (i_rst_b),
		.i_abort      (abort),
		.i_launch     (launch_q),
		.i_tick       (tick),
		.i_delay_code (ctrl3_q[`ADCSQ_C3_DLY_HI:`ADCSQ_C3_DLY_LO]),
		.o_sampling   (o_sample_hold),
		.o_converting (o_convert),
		.o_done       (done)
	);

endmodule // adcsq_top

`default_nettype wire

// ---- verification/adcsq_props.sv ----
// Checker for the scan sequencer: bus handshake and converter link.
// Assumes it is bound into adcsq_top and sees only its ports.
`timescale 1ns/1ns
`default_nettype none
module adcsq_props (
	input wire logic        i_clock,
	input wire logic        i_rst_b,
	input wire logic        i_wb_cyc,
	input wire logic        i_wb_stb,
	input wire logic        o_wb_ack,
	input wire logic [31:0] o_wb_dat,
	input wire logic [3:0]  o_mux_chan,
	input wire logic        o_sample_hold,
	input wire logic        o_convert,
	input wire logic        o_core_power,
	input wire logic        o_irq
);
default clocking cb @(posedge i_clock);
endclocking
default disable iff (!i_rst_b);
logic [8:0] run_q;
// Length of the running conversion, read when it ends
always @(posedge i_clock)
	run_q <= (!i_rst_b || !o_convert) ? 9'h000 : run_q + 9'h001;
////////////////////
ack_pulse_a:
	assert property (o_wb_ack |=> !o_wb_ack) else $error("ack held");
ack_answer_a:
	assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
		else $error("no ack");
dat_idle_a:
	assert property (!o_wb_ack |-> o_wb_dat == 32'h0000_0000)
		else $error("data without ack");
dat_byte_a:
	assert property (o_wb_ack |-> o_wb_dat[31:8] == 24'h00_0000)
		else $error("upper bytes set");
phase_excl_a:
	assert property (!(o_sample_hold && o_convert)) else $error("overlap");
sample_first_a:
	assert property ($rose(o_convert) |-> $past(o_sample_hold))
		else $error("no sampling delay");
conv_len_a:
	assert property ($fell(o_convert) |-> run_q inside {9'h00a,
		9'h014, 9'h028, 9'h050, 9'h0a0, 9'h140}) else $error("bad length");
mux_hold_a:
	assert property (o_convert |-> $stable(o_mux_chan))
		else $error("mux moved");
power_quiet_a:
	assert property (!o_core_power |=> !o_sample_hold && !o_convert
		&& !o_irq) else $error("active while off");
endmodule // adcsq_props
bind adcsq_top adcsq_props i_adcsq_props (.i_clock(i_clock),
	.i_rst_b(i_rst_b), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
	.o_wb_ack(o_wb_ack), .o_wb_dat(o_wb_dat), .o_mux_chan(o_mux_chan),
	.o_sample_hold(o_sample_hold), .o_convert(o_convert),
	.o_core_power(o_core_power), .o_irq(o_irq));
`default_nettype wire

// ---- verification/adcsq_core_model.sv ----
// Analog core stand-in: a fixed code for each input channel.
// Assumes the result is taken within two cycles after converting.
`timescale 1ns/1ns
`default_nettype none
module adcsq_core_model (
	input  wire logic       i_clock,
	input  wire logic [3:0] i_mux_chan,
	input  wire logic       i_convert,
	output var logic [7:0]  o_result
);
logic [1:0] live_q;
logic [7:0] code;
always @(posedge i_clock)
	live_q <= {live_q[0], i_convert};
assign code = {~i_mux_chan, i_mux_chan} ^ 8'h3c;
// Inverse outside the valid span, so a late sample shows
always @*
	o_result = (i_convert || |live_q) ? code : ~code;
endmodule // adcsq_core_model
`default_nettype wire

// ---- verification/adcsq_tb_top.sv ----
// Testbench for the scan sequencer: all modes, flags, abort.
// Assumes the core model answers each channel with a fixed code.
`timescale 1ns/1ns
`default_nettype none
`include "adcsq_consts.vh"
module adcsq_tb_top;
localparam logic [7:0] A_ST = `ADCSQ_OFS_STATUS;
localparam logic [7:0] A_C1 = `ADCSQ_OFS_CTRL_ONE;
localparam logic [7:0] A_C2 = `ADCSQ_OFS_CTRL_TWO;
localparam logic [7:0] A_C3 = `ADCSQ_OFS_CTRL_THR;
localparam logic [7:0] A_RS = `ADCSQ_OFS_RES_BASE;
logic        i_clock = 1'b0;
logic        i_rst_b = 1'b0;
logic        cyc = 1'b0;
logic        stb = 1'b0;
logic        we = 1'b0;
logic [7:0]  adr = 8'h00;
logic [3:0]  sel = 4'h0;
logic [31:0] wdat = 32'h0000_0000;
logic [31:0] rdat;
logic        ack;
logic [7:0]  sar;
logic [3:0]  mux;
logic        sh;
logic        conv;
logic        irq;
logic        pwr;
logic [7:0]  e;
int          miscompares = 0;
int          samples_checked = 0;
int          seed = 53;
logic [7:0]  q;
logic [3:0]  ch;
always #5 i_clock = ~i_clock;
adcsq_top i_adcsq_top (.i_clock(i_clock), .i_rst_b(i_rst_b),
	.i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
	.i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
	.i_sar_result(sar), .o_mux_chan(mux), .o_sample_hold(sh),
	.o_convert(conv), .o_core_power(pwr), .o_irq(irq));
adcsq_core_model i_adcsq_core_model (.i_clock(i_clock),
	.i_mux_chan(mux), .i_convert(conv), .o_result(sar));
////////////////////
task automatic stop_test;
	$display("checked %0d, errors %0d", samples_checked, miscompares);
	if (miscompares == 0 && samples_checked > 0)
		$display("TB: PASS");
	else
		$display("TB: FAIL");
	$finish;
endtask
task automatic chk(input logic [7:0] got, input logic [7:0] exp);
	samples_checked++;
	if (got !== exp) begin
		miscompares++;
		$display("Error %0t: got %h expected %h", $time, got, exp);
	end
endtask
function automatic logic [7:0] f_res(input logic [3:0] c);
	return {~c, c} ^ 8'h3c;
endfunction
task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
	output logic [7:0] r);
	int n;
	@(posedge i_clock);
	cyc <= 1'b1;
	stb <= 1'b1;
	we <= w;
	adr <= a;
	sel <= 4'h1;
	wdat <= {24'h00_0000, d};
	n = 0;
	do begin
		@(posedge i_clock);
		n++;
	end while (ack !== 1'b1 && n < 20);
	if (ack !== 1'b1) begin
		miscompares++;
		$display("Error %0t: bus timeout", $time);
		stop_test();
	end
	r = rdat[7:0];
	cyc <= 1'b0;
	stb <= 1'b0;
	we <= 1'b0;
endtask
task automatic wr(input logic [7:0] a, input logic [7:0] d);
	logic [7:0] t;
	wb(1'b1, a, d, t);
endtask
task automatic rd(input logic [7:0] a);
	wb(1'b0, a, 8'h00, q);
endtask
// Poll status until the masked bits match, bounded
task automatic poll(input logic [7:0] m, input logic [7:0] v);
	int n;
	n = 0;
	do begin
		rd(A_ST);
		n++;
	end while ((q & m) !== v && n < 400);
	chk(q & m, v);
	if ((q & m) !== v)
		stop_test();
endtask
////////////////////
initial begin
	repeat (20) @(posedge i_clock);
	i_rst_b <= 1'b1;
	rd(A_ST);
	chk(q, `ADCSQ_ST_RESET);
	rd(A_C2);
	chk(q, 8'h00);
	rd(8'h40);
	chk(q, 8'h00);
	wr(A_C3, 8'h00);
	for (int m = 0; m < 4; m++) begin
		wr(A_C1, 8'h04);
		wr(A_C1, 8'h05);
		rd(A_C1);
		chk(q, 8'h05);
		chk({7'h00, pwr}, 8'h01);
		ch = 4'($unsigned($random(seed)) % 9);
		wr(A_C2, {2'b10, m[0], m[1], ch});
		poll(8'h01, 8'h01);
		// Continuous modes keep running, so busy stays up
		e = {2'b00, {2{m != 0}}, 2'b00, m[1], 1'b1};
		chk(q & {m[1], 7'h7f}, e);
		chk({7'h00, irq}, 8'h01);
		rd(A_C2);
		chk({7'h00, q[7]}, {7'h00, m[1]});
		for (int i = 0; i < ((m == 0) ? 1 : 4); i++) begin
			rd(A_RS + 8'(4 * i));
			chk(q, f_res(m[0] ? ch + 4'(i) : ch));
		end
		rd(A_ST);
		chk(q & 8'h01, 8'h00);
		chk({7'h00, irq}, 8'h00);
		if (m[1]) begin
			wr(A_C2, {2'b10, ~m[0], 1'b0, ch});
			rd(A_C2);
			chk(q & 8'h70, {2'b00, m[0], 5'h10});
			poll(8'h04, 8'h04);
			wr(A_C2, {2'b00, m[0], 1'b1, ch});
			poll(8'h03, 8'h01);
			chk(q & {2'b00, {2{m[0]}}, 4'h0}, {2'b00, {2{m[0]}}, 4'h0});
			wr(A_ST, 8'hfb);
			rd(A_ST);
			chk(q & 8'h07, 8'h05);
			wr(A_ST, 8'h04);
			rd(A_ST);
			chk(q & 8'h07, 8'h01);
		end
	end
	wr(A_C3, 8'h30);
	wr(A_C2, {4'h8, ch});
	poll(8'h02, 8'h02);
	wr(A_C1, 8'h04);
	rd(A_ST);
	chk(q, 8'h30);
	chk({7'h00, pwr}, 8'h00);
	rd(A_C2);
	chk(q & 8'h80, 8'h00);
	wr(A_C2, 8'h80);
	rd(A_C2);
	chk(q & 8'h80, 8'h00);
	chk({7'h00, sh}, 8'h00);
	stop_test();
end
endmodule // adcsq_tb_top
`default_nettype wire
